// file: core/ptb_top.sv
// periodic timebase: AHB-Lite registers, flag, interrupt and divider
`timescale 1ns/1ps
`default_nettype none
`include "ptb_regs.svh"
module ptb_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [2:0] hburst,
  input wire logic [3:0] hprot,
  input wire logic hmastlock,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic oscillator_source_clock,
  output logic timebase_irq
);

  // address decode, shared by read and write paths
  function automatic ptb_pkg::ptb_sel_t dec(input logic [11:0] a);
    if (a == `PTB_OFF_CTRL) begin
      dec = ptb_pkg::PTB_SEL_CTRL;
    end else if (a == `PTB_OFF_CFG) begin
      dec = ptb_pkg::PTB_SEL_CFG;
    end else if (a == `PTB_OFF_STAT) begin
      dec = ptb_pkg::PTB_SEL_STAT;
    end else if (a == `PTB_OFF_MASK) begin
      dec = ptb_pkg::PTB_SEL_MASK;
    end else if (a == `PTB_OFF_CNT) begin
      dec = ptb_pkg::PTB_SEL_CNT;
    end else begin
      dec = ptb_pkg::PTB_SEL_NONE;
    end
  endfunction

  // bus-side state
  logic wr_pend;
  ptb_pkg::ptb_sel_t wr_sel;
  logic rd_go;
  ptb_pkg::ptb_sel_t rd_sel;
  logic addr_ok;
  logic wr_now;
  logic [7:0] wbyte;

  // control and status state
  logic rollover_flag;
  ptb_pkg::ptb_tap_t tap_select;
  logic rollover_irq_enable;
  logic divider_run;
  logic extra_prescale_select;
  logic [`PTB_EV_W-1:0] ev_status;
  logic [`PTB_EV_W-1:0] ev_mask;
  logic [`PTB_EV_W-1:0] ev_set;
  logic ev_roll;
  logic ev_tapw;
  logic ev_ovr;
  logic next_irq;

  // oscillator edge path
  logic osc_sync;
  logic osc_last;
  logic src_tick;

  // divider outputs
  logic [`PTB_CHAIN_W-1:0] chain;
  logic roll;

  // write-side strobes
  logic ctrl_wr;
  logic cfg_wr;
  logic stat_wr;
  logic mask_wr;
  logic ack_wr;
  logic tap_wr_run;

  // read mux
  logic [31:0] next_rdata;

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // only whole-word single transfers are expected from the master
  // size, burst, protection and lock are not decoded for that reason
  assign addr_ok = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_sel <= ptb_pkg::PTB_SEL_NONE;
    end else begin
      wr_pend <= addr_ok & hwrite;
      wr_sel <= dec(haddr[11:0]);
    end
  end

  assign rd_go = addr_ok & !hwrite;
  assign rd_sel = dec(haddr[11:0]);
  assign wr_now = wr_pend;
  assign wbyte = hwdata[7:0];

  // data-phase strobe for one register; a miss gives no strobe at all
  function automatic logic wr_hit(
    input logic pend,
    input ptb_pkg::ptb_sel_t sel,
    input ptb_pkg::ptb_sel_t want
  );
    wr_hit = pend & (sel == want);
  endfunction

  assign ctrl_wr = wr_hit(wr_now, wr_sel, ptb_pkg::PTB_SEL_CTRL);
  assign cfg_wr = wr_hit(wr_now, wr_sel, ptb_pkg::PTB_SEL_CFG);
  assign stat_wr = wr_hit(wr_now, wr_sel, ptb_pkg::PTB_SEL_STAT);
  assign mask_wr = wr_hit(wr_now, wr_sel, ptb_pkg::PTB_SEL_MASK);

  // ack only on a written one
  assign ack_wr = ctrl_wr & wbyte[`PTB_CTRL_ACK];

  // the tap is not locked by hardware; a change while running is reported
  assign tap_wr_run = ctrl_wr & divider_run
    & (wbyte[`PTB_CTRL_TAP_HI:`PTB_CTRL_TAP_LO] != tap_select);

  // ---------------------------------------------------------------
  // oscillator pin: two flops, then rising-edge detect
  // ---------------------------------------------------------------
  ptb_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(oscillator_source_clock),
    .pin_sync(osc_sync)
  );

  // the pin must run below half of hclk or edges are lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_last <= 1'b0;
    end else begin
      osc_last <= osc_sync;
    end
  end

  // both flops reset low, so a low pin gives no false tick after reset
  assign src_tick = osc_sync & !osc_last;

  // ---------------------------------------------------------------
  // divider chain
  // ---------------------------------------------------------------
  // chain and prescaler
  ptb_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_tick(src_tick),
    .run(divider_run),
    .xpre_sel(extra_prescale_select),
    .tap(tap_select),
    .chain(chain),
    .roll(roll)
  );

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  // tap select storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_select <= `PTB_RST_TAP;
    end else if (ctrl_wr) begin
      tap_select <= wbyte[`PTB_CTRL_TAP_HI:`PTB_CTRL_TAP_LO];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rollover_irq_enable <= `PTB_RST_IE;
    end else if (ctrl_wr) begin
      rollover_irq_enable <= wbyte[`PTB_CTRL_IE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      divider_run <= `PTB_RST_RUN;
    end else if (ctrl_wr) begin
      divider_run <= wbyte[`PTB_CTRL_RUN];
    end
  end

  // a change while running shifts the next flag; stop first
  // prescale option bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      extra_prescale_select <= `PTB_RST_XPRE;
    end else if (cfg_wr) begin
      extra_prescale_select <= wbyte[`PTB_CFG_XPRE];
    end
  end

  // ---------------------------------------------------------------
  // rollover flag: set wins over acknowledge
  // ---------------------------------------------------------------
  // set on overflow, cleared by ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rollover_flag <= 1'b0;
    end else if (roll) begin
      rollover_flag <= 1'b1;
    end else if (ack_wr) begin
      rollover_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sticky event status, write one to clear, set wins
  // ---------------------------------------------------------------
  assign ev_roll = roll;
  assign ev_tapw = tap_wr_run;
  // overrun: a rollover lands while the last one is still unacknowledged
  assign ev_ovr = roll & rollover_flag & !ack_wr;

  always_comb begin
    ev_set = '0;
    ev_set[`PTB_EV_ROLL] = ev_roll;
    ev_set[`PTB_EV_TAPW] = ev_tapw;
    ev_set[`PTB_EV_OVR] = ev_ovr;
  end

  genvar e;
  generate
    for (e = 0; e < `PTB_EV_W; e = e + 1) begin : g_ev
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ev_status[e] <= 1'b0;
        end else if (ev_set[e]) begin
          ev_status[e] <= 1'b1;
        end else if (stat_wr & wbyte[e]) begin
          ev_status[e] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_mask <= `PTB_RST_MASK;
    end else if (mask_wr) begin
      ev_mask <= wbyte[`PTB_EV_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // interrupt output, a level
  // ---------------------------------------------------------------
  // flag and enable, or any unmasked event status bit, held until cleared
  assign next_irq = (rollover_flag & rollover_irq_enable) | (|(ev_status & ev_mask));

  // registered, so decode glitches never reach the request line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timebase_irq <= 1'b0;
    end else begin
      timebase_irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // read data, registered at the address phase
  // ---------------------------------------------------------------
  // acknowledge slot always zero
  function automatic logic [7:0] ctrl_byte(
    input logic flag,
    input ptb_pkg::ptb_tap_t tap,
    input logic ie,
    input logic run
  );
    ctrl_byte = 8'h00;
    ctrl_byte[`PTB_CTRL_FLAG] = flag;
    ctrl_byte[`PTB_CTRL_TAP_HI:`PTB_CTRL_TAP_LO] = tap;
    ctrl_byte[`PTB_CTRL_ACK] = 1'b0;
    ctrl_byte[`PTB_CTRL_IE] = ie;
    ctrl_byte[`PTB_CTRL_RUN] = run;
  endfunction

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (rd_sel)
      ptb_pkg::PTB_SEL_CTRL: begin
        next_rdata[7:0] = ctrl_byte(rollover_flag, tap_select,
          rollover_irq_enable, divider_run);
      end
      ptb_pkg::PTB_SEL_CFG: begin
        next_rdata[`PTB_CFG_XPRE] = extra_prescale_select;
      end
      ptb_pkg::PTB_SEL_STAT: begin
        next_rdata[`PTB_EV_W-1:0] = ev_status;
      end
      ptb_pkg::PTB_SEL_MASK: begin
        next_rdata[`PTB_EV_W-1:0] = ev_mask;
      end
      ptb_pkg::PTB_SEL_CNT: begin
        next_rdata[`PTB_CHAIN_W-1:0] = chain;
      end
      ptb_pkg::PTB_SEL_NONE: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // write data lands one cycle after a read could see it, so a read
  // right after a write returns the new value only from the next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// file: shared/ptb_regs.svh
// register offsets, field positions and reset values of the periodic timebase
`ifndef PTB_REGS_SVH
`define PTB_REGS_SVH

`define PTB_OFF_CTRL 12'h000
`define PTB_OFF_CFG 12'h004
`define PTB_OFF_STAT 12'h008
`define PTB_OFF_MASK 12'h00c
`define PTB_OFF_CNT 12'h010

`define PTB_CTRL_FLAG 7
`define PTB_CTRL_TAP_LO 4
`define PTB_CTRL_TAP_HI 6
`define PTB_CTRL_ACK 3
`define PTB_CTRL_IE 2
`define PTB_CTRL_RUN 1

`define PTB_CFG_XPRE 0

`define PTB_EV_ROLL 0
`define PTB_EV_TAPW 1
`define PTB_EV_OVR 2
`define PTB_EV_W 3

`define PTB_RST_TAP 3'h0
`define PTB_RST_IE 1'b0
`define PTB_RST_RUN 1'b0
`define PTB_RST_XPRE 1'b0
`define PTB_RST_MASK 3'h0

`define PTB_CHAIN_W 15
`define PTB_PRE_W 7
`define PTB_PRE_LAST 7'h7f

`define PTB_TAP0_BIT 4'he
`define PTB_TAP1_BIT 4'hc
`define PTB_TAP2_BIT 4'ha
`define PTB_TAP3_BIT 4'h6
`define PTB_TAP4_BIT 4'h5
`define PTB_TAP5_BIT 4'h4
`define PTB_TAP6_BIT 4'h3
`define PTB_TAP7_BIT 4'h2

`endif

// file: shared/ptb_pkg.sv
// types shared by the periodic timebase files
package ptb_pkg;
  typedef enum logic [2:0] {
    PTB_SEL_CTRL,
    PTB_SEL_CFG,
    PTB_SEL_STAT,
    PTB_SEL_MASK,
    PTB_SEL_CNT,
    PTB_SEL_NONE
  } ptb_sel_t;
  typedef logic [2:0] ptb_tap_t;
endpackage

// file: core/ptb_sync.sv
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module ptb_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic pin_sync
);
  logic meta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta <= pin_in;
      pin_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// file: core/ptb_divider.sv
// optional divide-by-128 prescaler and fifteen-stage divider chain
`timescale 1ns/1ps
`default_nettype none
`include "ptb_regs.svh"
module ptb_divider (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic src_tick,
  input wire logic run,
  input wire logic xpre_sel,
  input wire ptb_pkg::ptb_tap_t tap,
  output logic [`PTB_CHAIN_W-1:0] chain,
  output logic roll
);
  logic [`PTB_PRE_W-1:0] pre;
  logic adv;
  logic [`PTB_CHAIN_W-1:0] next_chain;
  logic [`PTB_CHAIN_W-1:0] carry;
  logic [3:0] tap_idx;

  function automatic logic [3:0] tap_bit(input ptb_pkg::ptb_tap_t t);
    unique case (t)
      3'h0: tap_bit = `PTB_TAP0_BIT;
      3'h1: tap_bit = `PTB_TAP1_BIT;
      3'h2: tap_bit = `PTB_TAP2_BIT;
      3'h3: tap_bit = `PTB_TAP3_BIT;
      3'h4: tap_bit = `PTB_TAP4_BIT;
      3'h5: tap_bit = `PTB_TAP5_BIT;
      3'h6: tap_bit = `PTB_TAP6_BIT;
      3'h7: tap_bit = `PTB_TAP7_BIT;
    endcase
  endfunction

  assign adv = src_tick & (!xpre_sel | (pre == `PTB_PRE_LAST));
  assign tap_idx = tap_bit(tap);

  // each stage toggles when all lower stages are set
  genvar g;
  generate
    for (g = 0; g < `PTB_CHAIN_W; g = g + 1) begin : g_stage
      if (g == 0) begin : g_first
        assign carry[g] = adv;
      end else begin : g_rest
        assign carry[g] = carry[g-1] & chain[g-1];
      end
      assign next_chain[g] = chain[g] ^ carry[g];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre <= '0;
    end else if (!run) begin
      pre <= '0;
    end else if (src_tick) begin
      pre <= pre + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain <= '0;
    end else if (!run) begin
      chain <= '0;
    end else begin
      chain <= next_chain;
    end
  end

  // tap rising edge, half period first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      roll <= 1'b0;
    end else begin
      roll <= run & adv & next_chain[tap_idx] & !chain[tap_idx];
    end
  end
endmodule
`default_nettype wire

// file: testbench/ptb_osc_model.sv
// free-running source oscillator driving the timebase pin
`timescale 1ns/1ps
`default_nettype none
module ptb_osc_model #(
  parameter int HALF_NS = 20
) (
  output logic osc_clk
);
  // four hclk per period keeps every tap delay an exact count
  initial osc_clk = 1'b0;
  always #(HALF_NS) osc_clk = ~osc_clk;
endmodule
`default_nettype wire

// file: testbench/ptb_chk_sva.sv
// assertions on the timebase bus and interrupt ports
`timescale 1ns/1ps
`default_nettype none
module ptb_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic timebase_irq
);
  logic take;
  logic wr_q;
  logic [11:0] a_q;
  logic [6:0] ctrl_sh;
  logic [2:0] mask_sh;
  logic [1:0] stop_n;
  assign take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      a_q <= 12'h000;
    end else begin
      wr_q <= take && hwrite;
      a_q <= haddr[11:0];
    end
  end
  // shadows land on the data-phase edge, as the registers do
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_sh <= 7'h00;
      mask_sh <= 3'h0;
    end else if (wr_q && a_q == 12'h000) begin
      ctrl_sh <= hwdata[6:0] & 7'h76;
    end else if (wr_q && a_q == 12'h00c) begin
      mask_sh <= hwdata[2:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_n <= 2'h3;
    end else if (ctrl_sh[1]) begin
      stop_n <= 2'h0;
    end else if (stop_n != 2'h3) begin
      stop_n <= stop_n + 2'h1;
    end
  end
  sequence s_rd(logic [11:0] a);
    take && !hwrite && haddr[11:0] == a;
  endsequence
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_okay:
    assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bus answer not okay");
  a_ctrl_readback:
    assert property (s_rd(12'h000) |=> hrdata[6:0] == $past(ctrl_sh))
    else $error("control read differs from last write");
  a_ack_zero:
    assert property (s_rd(12'h000) |=> !hrdata[3] && hrdata[31:8] == 24'h0)
    else $error("acknowledge bit read back nonzero");
  a_irq_flag_en:
    assert property (s_rd(12'h000) ##1 $past(mask_sh) == 3'h0 |->
      timebase_irq == (hrdata[7] && hrdata[2])) else $error("irq not flag and enable");
  a_ie_off:
    assert property (wr_q && a_q == 12'h000 && !hwdata[2] && mask_sh == 3'h0 |->
      ##2 !timebase_irq) else $error("irq stays after enable cleared");
  a_chain_held:
    assert property (s_rd(12'h010) ##0 stop_n == 2'h3 |=> hrdata == 32'h0)
    else $error("stopped chain not zero");
  a_unmapped_zero:
    assert property (take && !hwrite && haddr[11:0] > 12'h010 |=> hrdata == 32'h0)
    else $error("unmapped read nonzero");
  a_irq_reset:
    assert property ($rose(hresetn) |-> !timebase_irq) else $error("irq high after reset");
endmodule
bind ptb_top ptb_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timebase_irq(timebase_irq));
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the periodic timebase
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic osc;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int ratio [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
  always #5 hclk = ~hclk;
  ptb_osc_model i_osc (.osc_clk(osc));
  ptb_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hburst(3'h0), .hprot(4'h0),
    .hmastlock(1'b0), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .oscillator_source_clock(osc), .timebase_irq(irq));
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, well above the longest tap wait
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, q, e);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(negedge hclk);
      n++;
    end
  endtask
  task automatic irq_is(input logic v, input string n);
    repeat (2) @(negedge hclk);
    chk(n, {31'h0, irq}, {31'h0, v});
  endtask
  task automatic t_reset();
    rd(12'h000, 32'h0, "ctrl_rst");
    rd(12'h010, 32'h0, "chain_rst");
    irq_is(1'b0, "irq_rst");
  endtask
  task automatic t_taps();
    int n;
    int t1;
    logic [7:0] b;
    for (int c = 0; c < 8; c++) begin
      rd(12'h000, 32'((c > 0 ? c - 1 : 0) << 4), "stopped");
      wr(12'h000, 32'(c << 4));
      rd(12'h000, 32'(c << 4), "tap");
      if (c >= 2) begin
        b = 8'(c << 4) | 8'h06;
        wr(12'h000, {24'h0, b});
        wait_irq(n);
        t1 = cyc;
        chk("first", 32'(n >= ratio[c] * 2 - 4 && n <= ratio[c] * 2 + 12), 32'h1);
        wr(12'h000, {24'h0, b});
        rd(12'h000, {24'h0, b | 8'h80}, "flag");
        wr(12'h000, {24'h0, b | 8'h08});
        rd(12'h000, {24'h0, b}, "ack");
        wait_irq(n);
        chk("period", 32'(cyc - t1), 32'(ratio[c] * 4));
        wr(12'h000, 32'(c << 4) | 32'h8);
      end
    end
  endtask
  task automatic t_prescale();
    int n;
    wr(12'h004, 32'h1);
    rd(12'h004, 32'h1, "cfg");
    wr(12'h000, 32'h76);
    wait_irq(n);
    chk("prescaled", 32'(n >= 2044 && n <= 2060), 32'h1);
    wr(12'h000, 32'h78);
    wr(12'h004, 32'h0);
  endtask
  task automatic t_stop();
    wr(12'h008, 32'h7);
    wr(12'h000, 32'h72);
    repeat (60) @(posedge hclk);
    wr(12'h000, 32'h70);
    repeat (2) @(posedge hclk);
    rd(12'h010, 32'h0, "chain_held");
    rd(12'h000, 32'hf0, "flag_kept");
    rd(12'h008, 32'h5, "roll_overrun");
    irq_is(1'b0, "irq_disabled");
    wr(12'h000, 32'h78);
  endtask
  task automatic t_events();
    int n;
    wr(12'h008, 32'h7);
    wr(12'h00c, 32'h1);
    irq_is(1'b0, "idle_mask");
    wr(12'h000, 32'h72);
    wait_irq(n);
    chk("event_irq", 32'(n > 8 && n < 40), 32'h1);
    wr(12'h000, 32'h70);
    wr(12'h00c, 32'h0);
    irq_is(1'b0, "masked");
    wr(12'h00c, 32'h1);
    irq_is(1'b1, "unmasked");
    wr(12'h008, 32'h7);
    wr(12'h000, 32'h78);
    rd(12'h008, 32'h0, "stat_clear");
    irq_is(1'b0, "irq_clear");
    rd(12'h020, 32'h0, "unmapped");
  endtask
  // reset in mid-run clears enable and run
  task automatic t_rerst();
    wr(12'h000, 32'h76);
    repeat (30) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(12'h000, 32'h0, "ctrl_rerst");
    irq_is(1'b0, "irq_rerst");
    rd(12'h010, 32'h0, "chain_rerst");
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_taps();
    t_prescale();
    t_stop();
    t_events();
    t_rerst();
    test_done();
  end
endmodule
`default_nettype wire
